/* hdl/fsq_dev.sv */
// Codec end: chroma-red statistics, quantizer table and field timing.
`timescale 1ns/1ps
module fsq_dev #(
	parameter int H_TOTAL_P = fsq_pkg::H_TOTAL,
	parameter int H_BLANK_P = fsq_pkg::H_BLANK,
	parameter int V_TOTAL_P = fsq_pkg::V_TOTAL,
	parameter int V_BLANK_P = fsq_pkg::V_BLANK
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Link to the host controller
	fsq_if.dev link,
	// Chroma-red sample stream
	input wire logic [fsq_pkg::DATA_W-1:0] cr_sample,
	input wire logic cr_valid,
	// Quantizer table read port
	input wire logic [5:0] q_pair,
	output logic [fsq_pkg::DATA_W-1:0] q_bin_width,
	output logic [fsq_pkg::DATA_W-1:0] q_recip_width,
	// Frame state
	output logic active_video,
	output logic field_one,
	// DSP serial port
	output logic dsp_tx_bit,
	output logic dsp_tx_frame,
	input wire logic dsp_rx_bit,
	input wire logic dsp_rx_frame
);
	import fsq_pkg::*;

	// ***************************************************************
	// Helper functions
	// ***************************************************************
	// True when an index falls inside the quantizer table.
	function automatic logic in_tbl(input logic [IDX_W-1:0] idx);
		in_tbl = (idx >= IDX_TBL_FIRST) && (idx <= IDX_TBL_LAST);
	endfunction

	// Entry number inside the table.
	function automatic logic [6:0] tbl_off(input logic [IDX_W-1:0] idx);
		logic [IDX_W-1:0] d;
		d = idx - IDX_TBL_FIRST;
		tbl_off = d[6:0];
	endfunction

	// ***************************************************************
	// State
	// ***************************************************************
	logic [3:0] mode_r;
	logic [9:0] h_cnt_r;
	logic [8:0] v_cnt_r;
	logic fld_r;
	logic vblank_d_r;
	logic [DATA_W-1:0] run_min_r, run_max_r, cr_min_r, cr_max_r;
	logic stats_r;
	logic [DATA_W-1:0] shadow_mem [TBL_ENTRIES];
	logic [DATA_W-1:0] active_mem [TBL_ENTRIES];
	logic copying_r;
	logic [6:0] copy_cnt_r;
	logic [31:0] tx_sr_r;
	logic [5:0] tx_cnt_r;
	logic [31:0] rx_sr_r;
	logic [5:0] rx_cnt_r;
	logic dsp_pend_r;
	logic [31:0] dsp_word_r;
	logic [31:0] rdata_r;
	logic rvalid_r;
	logic clk_tog_r;
	logic vs_o_r, hs_o_r, fd_o_r, oe_r, enc_r, stats_pin_r;
	logic act_r, fone_r;
	logic [DATA_W-1:0] qbw_r, qrbw_r;

	// ***************************************************************
	// Timing selection and decode
	// ***************************************************************
	// Master timing comes from the counters, slave timing from the pins.
	wire master = mode_r[MODE_MASTER];
	wire hs_inv = mode_r[MODE_HS_INV];
	wire h_wrap = (h_cnt_r == 10'(H_TOTAL_P - 1));
	wire v_wrap = (v_cnt_r == 9'(V_TOTAL_P - 1));
	wire m_hblank = (h_cnt_r < 10'(H_BLANK_P));
	wire m_vblank = (v_cnt_r < 9'(V_BLANK_P));
	wire m_field = ~fld_r;
	wire vblank = master ? m_vblank : link.vsync_line;
	wire hblank = master ? m_hblank : (link.hsync_line ^ hs_inv);
	wire field = master ? m_field : link.field_line;
	wire active = ~vblank & ~hblank;
	wire field_start = vblank_d_r & ~vblank;
	wire field_end = ~vblank_d_r & vblank;
	wire take = active & cr_valid;

	// Register port decode.
	wire wr_mode = link.reg_wr && (link.reg_index == IDX_MODE);
	wire wr_stat = link.reg_wr && (link.reg_index == IDX_STATUS);
	wire wr_tbl = link.reg_wr && in_tbl(link.reg_index);
	wire [IDX_W-1:0] rx_idx = dsp_word_r[31:16] < 16'h0400 ? dsp_word_r[25:16] : 10'h3ff;
	wire dsp_wr = dsp_pend_r && !wr_tbl && in_tbl(rx_idx);
	wire [6:0] tbl_wa = wr_tbl ? tbl_off(link.reg_index) : tbl_off(rx_idx);
	wire [DATA_W-1:0] tbl_wd = wr_tbl ? link.reg_wdata : dsp_word_r[15:0];
	wire pair_ok = (q_pair < 6'(TBL_PAIRS));
	wire rx_done = dsp_rx_frame && (rx_cnt_r == 6'(DSP_BITS - 1));

	// Read data mux; everything above the 16-bit value reads zero.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (link.reg_index == IDX_MODE) begin
			rd_mux = {28'h000_0000, mode_r};
		end else if (link.reg_index == IDX_STATUS) begin
			rd_mux = {31'h0000_0000, stats_r};
		end else if (link.reg_index == IDX_CR_MIN) begin
			rd_mux = {16'h0000, cr_min_r};
		end else if (link.reg_index == IDX_CR_MAX) begin
			rd_mux = {16'h0000, cr_max_r};
		end else if (in_tbl(link.reg_index)) begin
			rd_mux = {16'h0000, shadow_mem[tbl_off(link.reg_index)]};
		end
	end

	// ***************************************************************
	// Control, timing and statistics
	// ***************************************************************
	// Mode register and field timing counters.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r <= MODE_RESET;
			h_cnt_r <= 10'h000;
			v_cnt_r <= 9'h000;
			fld_r <= 1'b0;
			vblank_d_r <= 1'b1;
		end else begin
			if (wr_mode) begin
				mode_r <= link.reg_wdata[3:0];
			end
			h_cnt_r <= (!master || h_wrap) ? 10'h000 : h_cnt_r + 10'h001;
			if (!master) begin
				v_cnt_r <= 9'h000;
				fld_r <= 1'b0;
			end else if (h_wrap) begin
				v_cnt_r <= v_wrap ? 9'h000 : v_cnt_r + 9'h001;
				fld_r <= fld_r ^ v_wrap;
			end
			vblank_d_r <= vblank;
		end
	end

	// Running trackers restart at field start and latch at field end.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			run_min_r <= 16'hffff;
			run_max_r <= 16'h0000;
			cr_min_r <= 16'h0000;
			cr_max_r <= 16'h0000;
			stats_r <= 1'b0;
		end else begin
			if (field_start) begin
				run_min_r <= take ? cr_sample : 16'hffff;
				run_max_r <= take ? cr_sample : 16'h0000;
			end else if (take) begin
				run_min_r <= (cr_sample < run_min_r) ? cr_sample : run_min_r;
				run_max_r <= (cr_sample > run_max_r) ? cr_sample : run_max_r;
			end
			if (field_end) begin
				cr_min_r <= run_min_r;
				cr_max_r <= run_max_r;
			end
			// A new result wins over a clear in the same cycle.
			stats_r <= field_end | (stats_r & ~(wr_stat & link.reg_wdata[STAT_READY]));
		end
	end

	// ***************************************************************
	// Quantizer table
	// ***************************************************************
	// Host writes go first; a DSP word waits while the host writes.
	always_ff @(posedge core_clk) begin
		if (wr_tbl || dsp_wr) begin
			shadow_mem[tbl_wa] <= tbl_wd;
		end
		if (copying_r) begin
			active_mem[copy_cnt_r] <= shadow_mem[copy_cnt_r];
		end
	end

	// Copy runs in vertical blanking so a field sees one set of widths.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			copying_r <= 1'b0;
			copy_cnt_r <= 7'h00;
		end else if (field_end) begin
			copying_r <= 1'b1;
			copy_cnt_r <= 7'h00;
		end else if (copying_r) begin
			copying_r <= (copy_cnt_r != 7'(TBL_ENTRIES - 1));
			copy_cnt_r <= copy_cnt_r + 7'h01;
		end
	end

	// ***************************************************************
	// DSP serial port
	// ***************************************************************
	// Sends minimum then maximum, MSB first; receives index and entry.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_sr_r <= 32'h0000_0000;
			tx_cnt_r <= 6'h00;
			rx_sr_r <= 32'h0000_0000;
			rx_cnt_r <= 6'h00;
			dsp_pend_r <= 1'b0;
			dsp_word_r <= 32'h0000_0000;
		end else begin
			if (field_end) begin
				tx_sr_r <= {run_min_r, run_max_r};
				tx_cnt_r <= 6'(DSP_BITS);
			end else if (tx_cnt_r != 6'h00) begin
				tx_sr_r <= {tx_sr_r[30:0], 1'b0};
				tx_cnt_r <= tx_cnt_r - 6'h01;
			end
			rx_sr_r <= dsp_rx_frame ? {rx_sr_r[30:0], dsp_rx_bit} : 32'h0000_0000;
			rx_cnt_r <= (dsp_rx_frame && !rx_done) ? rx_cnt_r + 6'h01 : 6'h00;
			if (rx_done) begin
				dsp_pend_r <= 1'b1;
				dsp_word_r <= {rx_sr_r[30:0], dsp_rx_bit};
			end else if (!wr_tbl) begin
				dsp_pend_r <= 1'b0;
			end
		end
	end

	// ***************************************************************
	// Outputs
	// ***************************************************************
	// Registered pins, read answer and quantizer pair.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_r <= 32'h0000_0000;
			rvalid_r <= 1'b0;
			clk_tog_r <= 1'b0;
			{vs_o_r, hs_o_r, fd_o_r, oe_r} <= 4'h0;
			{enc_r, stats_pin_r, act_r, fone_r} <= 4'h0;
			qbw_r <= 16'h0000;
			qrbw_r <= 16'h0000;
		end else begin
			rdata_r <= link.reg_rd ? rd_mux : rdata_r;
			rvalid_r <= link.reg_rd;
			clk_tog_r <= ~clk_tog_r;
			vs_o_r <= m_vblank;
			hs_o_r <= m_hblank ^ hs_inv;
			fd_o_r <= m_field;
			oe_r <= master;
			enc_r <= mode_r[MODE_ENCODE];
			stats_pin_r <= field_end | stats_r;
			act_r <= active;
			fone_r <= field;
			// Odd entry is the 8.8 bin width, even the 6.10 reciprocal.
			qbw_r <= pair_ok ? active_mem[{q_pair, 1'b1}] : 16'h0000;
			qrbw_r <= pair_ok ? active_mem[{q_pair, 1'b0}] : 16'h0000;
		end
	end

	// Pin and port assignments.
	assign link.reg_rdata = rdata_r;
	assign link.reg_rvalid = rvalid_r;
	assign link.vsync_dev_o = vs_o_r;
	assign link.hsync_dev_o = hs_o_r;
	assign link.field_dev_o = fd_o_r;
	assign link.vsync_dev_oe = oe_r;
	assign link.hsync_dev_oe = oe_r;
	assign link.field_dev_oe = oe_r;
	assign link.coding_direction = enc_r;
	assign link.stats_ready = stats_pin_r;
	// Undivided mode passes the clock itself; it cannot come from a flop.
	assign link.video_clock_out = mode_r[MODE_CLK_DIV2] ? clk_tog_r : core_clk;
	assign q_bin_width = qbw_r;
	assign q_recip_width = qrbw_r;
	assign active_video = act_r;
	assign field_one = fone_r;
	assign dsp_tx_bit = tx_sr_r[31];
	assign dsp_tx_frame = (tx_cnt_r != 6'h00);
endmodule

/* hdl/fsq_pkg.sv */
// Shared constants for the field statistics and quantizer register bank.
package fsq_pkg;
	// ***************************************************************
	// Indirect register indices and widths
	// ***************************************************************
	localparam int IDX_W = 10;
	localparam int DATA_W = 16;
	localparam logic [9:0] IDX_MODE = 10'h000;
	localparam logic [9:0] IDX_STATUS = 10'h001;
	localparam logic [9:0] IDX_CR_MIN = 10'h0b1;
	localparam logic [9:0] IDX_CR_MAX = 10'h0b2;
	localparam logic [9:0] IDX_TBL_FIRST = 10'h100;
	localparam logic [9:0] IDX_TBL_LAST = 10'h153;
	localparam int TBL_ENTRIES = 84;
	localparam int TBL_PAIRS = 42;
	// Mode control bit positions and reset value.
	localparam int MODE_MASTER = 0;
	localparam int MODE_HS_INV = 1;
	localparam int MODE_CLK_DIV2 = 2;
	localparam int MODE_ENCODE = 3;
	localparam logic [3:0] MODE_RESET = 4'h0;
	localparam int STAT_READY = 0;
	// Bin width is 8.8 and reciprocal width is 6.10, both unsigned.
	localparam int BW_FRAC_BITS = 8;
	localparam int RBW_FRAC_BITS = 10;
	// ***************************************************************
	// Master timing defaults in clock cycles and lines
	// ***************************************************************
	localparam int H_TOTAL = 858;
	localparam int H_BLANK = 138;
	localparam int V_TOTAL = 262;
	localparam int V_BLANK = 20;
	// Serial port frame length in bits.
	localparam int DSP_BITS = 32;
	// ***************************************************************
	// Controller register byte offsets
	// ***************************************************************
	localparam logic [4:0] A_INDEX = 5'h00;
	localparam logic [4:0] A_WDATA = 5'h04;
	localparam logic [4:0] A_CTRL = 5'h08;
	localparam logic [4:0] A_STATUS = 5'h0c;
	localparam logic [4:0] A_RDATA = 5'h10;
	localparam int CTRL_WR = 0;
	localparam int CTRL_RD = 1;
endpackage

/* hdl/fsq_if.sv */
// Interface joining the codec register end and its host controller end.
`timescale 1ns/1ps
interface fsq_if;
	import fsq_pkg::*;
	// Indirect register port.
	logic [IDX_W-1:0] reg_index;
	logic [DATA_W-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic reg_rvalid;
	// Two-way sync pins, split into drive, enable and line level.
	logic vsync_dev_o, vsync_dev_oe, vsync_host_o, vsync_host_oe, vsync_line;
	logic hsync_dev_o, hsync_dev_oe, hsync_host_o, hsync_host_oe, hsync_line;
	logic field_dev_o, field_dev_oe, field_host_o, field_host_oe, field_line;
	// Plain device outputs.
	logic video_clock_out;
	logic coding_direction;
	logic stats_ready;
	// Wire levels resolved from the enables; an undriven vsync is pulled up to blanking,
	// so no false field edge follows reset; the other lines read low when undriven.
	assign vsync_line = vsync_dev_oe ? vsync_dev_o : (~vsync_host_oe | vsync_host_o);
	assign hsync_line = hsync_dev_oe ? hsync_dev_o : (hsync_host_oe & hsync_host_o);
	assign field_line = field_dev_oe ? field_dev_o : (field_host_oe & field_host_o);
	modport dev (
		input reg_index, reg_wdata, reg_wr, reg_rd,
		output reg_rdata, reg_rvalid,
		output vsync_dev_o, vsync_dev_oe, hsync_dev_o, hsync_dev_oe, field_dev_o, field_dev_oe,
		input vsync_line, hsync_line, field_line,
		output video_clock_out, coding_direction, stats_ready
	);
	modport host (
		output reg_index, reg_wdata, reg_wr, reg_rd,
		input reg_rdata, reg_rvalid,
		output vsync_host_o, vsync_host_oe, hsync_host_o, hsync_host_oe,
		output field_host_o, field_host_oe,
		input vsync_dev_oe, vsync_line, hsync_line, field_line,
		input video_clock_out, coding_direction, stats_ready
	);
endinterface

/* hdl/fsq_host.sv */
// Host end: AXI4-Lite slave that drives the indirect port and sync pins.
`timescale 1ns/1ps
module fsq_host (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Link to the codec
	fsq_if.host link,
	// AXI4-Lite write channels
	input wire logic [4:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read channels
	input wire logic [4:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// External timing source used while the codec is timing slave
	input wire logic ext_vsync,
	input wire logic ext_hsync,
	input wire logic ext_field
);
	import fsq_pkg::*;

	// Merges the enabled byte lanes of a write into an old value.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction

	// ***************************************************************
	// State
	// ***************************************************************
	logic [31:0] index_r, wdata_r, rdata_r, ard_r;
	logic busy_r, reg_wr_r, reg_rd_r;
	logic awready_r, bvalid_r, arready_r, rvalid_r;
	logic vs_r, hs_r, fd_r, oe_r;

	// Handshake decode.
	wire aw_ok = s_axi_awvalid & s_axi_wvalid & ~bvalid_r & ~awready_r;
	wire w_fire = awready_r & s_axi_awvalid & s_axi_wvalid;
	wire ar_ok = s_axi_arvalid & ~arready_r & ~rvalid_r;
	wire r_fire = arready_r & s_axi_arvalid;
	wire ctrl_hit = w_fire && (s_axi_awaddr == A_CTRL) && !busy_r;
	wire go_wr = ctrl_hit && s_axi_wstrb[0] && s_axi_wdata[CTRL_WR];
	wire go_rd = ctrl_hit && s_axi_wstrb[0] && s_axi_wdata[CTRL_RD] && !go_wr;
	wire [31:0] status = {29'h0000_0000, link.coding_direction, link.stats_ready, busy_r};

	// Read mux of the controller registers; unmapped reads give zero.
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (s_axi_araddr)
			A_INDEX: rd_mux = index_r;
			A_WDATA: rd_mux = wdata_r;
			A_STATUS: rd_mux = status;
			A_RDATA: rd_mux = rdata_r;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// ***************************************************************
	// AXI4-Lite slave
	// ***************************************************************
	// Address and data are taken together, one cycle after both show.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			awready_r <= 1'b0;
			bvalid_r <= 1'b0;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			ard_r <= 32'h0000_0000;
		end else begin
			awready_r <= aw_ok;
			bvalid_r <= w_fire | (bvalid_r & ~s_axi_bready);
			arready_r <= ar_ok;
			rvalid_r <= r_fire | (rvalid_r & ~s_axi_rready);
			ard_r <= r_fire ? rd_mux : ard_r;
		end
	end

	// ***************************************************************
	// Indirect port sequencer
	// ***************************************************************
	// A write strobe ends the command at once; a read waits for the answer.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			index_r <= 32'h0000_0000;
			wdata_r <= 32'h0000_0000;
			rdata_r <= 32'h0000_0000;
			busy_r <= 1'b0;
			reg_wr_r <= 1'b0;
			reg_rd_r <= 1'b0;
		end else begin
			if (w_fire && s_axi_awaddr == A_INDEX) begin
				index_r <= merge(index_r, s_axi_wdata, s_axi_wstrb) & 32'h0000_03ff;
			end
			if (w_fire && s_axi_awaddr == A_WDATA) begin
				wdata_r <= merge(wdata_r, s_axi_wdata, s_axi_wstrb) & 32'h0000_ffff;
			end
			reg_wr_r <= go_wr;
			reg_rd_r <= go_rd;
			if (link.reg_rvalid) begin
				rdata_r <= link.reg_rdata;
			end
			busy_r <= go_wr | go_rd | (busy_r & ~reg_wr_r & ~link.reg_rvalid);
		end
	end

	// ***************************************************************
	// Sync pins
	// ***************************************************************
	// Drives the sync pins while the codec did not drive them one cycle earlier.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{vs_r, hs_r, fd_r, oe_r} <= 4'h0;
		end else begin
			vs_r <= ext_vsync;
			hs_r <= ext_hsync;
			fd_r <= ext_field;
			oe_r <= ~link.vsync_dev_oe;
		end
	end

	// Port assignments.
	assign link.reg_index = index_r[IDX_W-1:0];
	assign link.reg_wdata = wdata_r[DATA_W-1:0];
	assign link.reg_wr = reg_wr_r;
	assign link.reg_rd = reg_rd_r;
	assign link.vsync_host_o = vs_r;
	assign link.hsync_host_o = hs_r;
	assign link.field_host_o = fd_r;
	assign link.vsync_host_oe = oe_r;
	assign link.hsync_host_oe = oe_r;
	assign link.field_host_oe = oe_r;
	assign s_axi_awready = awready_r;
	assign s_axi_wready = awready_r;
	assign s_axi_bresp = 2'h0;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rdata = ard_r;
	assign s_axi_rresp = 2'h0;
	assign s_axi_rvalid = rvalid_r;
endmodule

/* testbench/fsq_link_monitor.sv */
// Checker on the link between the codec end and the host end.
`timescale 1ns/1ps
module fsq_link_monitor #(
	parameter int H_TOTAL_P = 16,
	parameter int H_BLANK_P = 4,
	parameter int V_TOTAL_P = 8,
	parameter int V_BLANK_P = 2
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// Indirect port
	input wire logic [fsq_pkg::IDX_W-1:0] reg_index,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	// Pins
	input wire logic vsync_dev_o,
	input wire logic vsync_dev_oe,
	input wire logic hsync_dev_o,
	input wire logic field_dev_o,
	input wire logic vsync_line,
	input wire logic coding_direction,
	input wire logic stats_ready
);
	import fsq_pkg::*;
	logic [2:0] pin_now;
	logic [2:0] pin_prev_r;
	int run_r [3];
	int quiet_r;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	assign pin_now = {field_dev_o, vsync_dev_o, hsync_dev_o};
	// Run lengths of each sync pin, and cycles since the last indirect write.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_prev_r <= 3'h0;
			quiet_r <= 0;
			run_r <= '{0, 0, 0};
		end else begin
			pin_prev_r <= pin_now;
			quiet_r <= reg_wr ? 0 : quiet_r + 1;
			for (int i = 0; i < 3; i++) begin
				run_r[i] <= (pin_now[i] != pin_prev_r[i]) ? 1 : run_r[i] + 1;
			end
		end
	end
	rd_answer_a: assert property (reg_rd |=> reg_rvalid ##1 !reg_rvalid)
		else $error("read answer missing");
	rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read answer without request");
	stat_upper_a: assert property (reg_rvalid && ($past(reg_index) == IDX_CR_MIN ||
		$past(reg_index) == IDX_CR_MAX) |-> reg_rdata[31:16] == 16'h0000)
		else $error("statistic upper half not zero");
	oe_change_a: assert property ($changed(vsync_dev_oe) |->
		$past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
		else $error("sync direction changed without a write");
	line_run_a: assert property (vsync_dev_oe && $changed(hsync_dev_o) &&
		quiet_r > run_r[0] + 3 |-> run_r[0] == H_BLANK_P || run_r[0] == H_TOTAL_P - H_BLANK_P)
		else $error("horizontal sync run length wrong");
	blank_run_a: assert property (vsync_dev_oe && $changed(vsync_dev_o) &&
		quiet_r > run_r[1] + 3 |-> run_r[1] == V_BLANK_P * H_TOTAL_P ||
		run_r[1] == (V_TOTAL_P - V_BLANK_P) * H_TOTAL_P)
		else $error("vertical sync run length wrong");
	field_id_a: assert property (vsync_dev_oe && $changed(field_dev_o) &&
		quiet_r > run_r[2] + 3 |-> run_r[2] == V_TOTAL_P * H_TOTAL_P)
		else $error("field pin run length wrong");
	coding_dir_a: assert property ($changed(coding_direction) |->
		$past(reg_wr, 2) && $past(reg_index, 2) == IDX_MODE)
		else $error("coding direction changed without a mode write");
	stats_ready_a: assert property ($rose(stats_ready) |-> vsync_line)
		else $error("statistics ready outside blanking");
endmodule

/* testbench/tb.sv */
// Self-checking bench for the codec end and host end joined by their link.
`timescale 1ns/1ps
module tb;
	import fsq_pkg::*;
	logic core_clk = 0;
	logic rst_b = 0;
	logic [4:0] awaddr = 0, araddr = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, field_one, tx_bit, tx_frame;
	logic [31:0] wdata = 0, rdata, s, r, tx_word = 0, dsp_w = 32'h0102_3c5a;
	logic ext_vsync = 1, ext_hsync = 0, ext_field = 0, cr_valid = 0, rx_bit = 0, rx_frame = 0, act;
	logic [3:0] wstrb = 4'hf;
	logic [15:0] cr_sample = 0, qbw, qrw;
	logic [5:0] q_pair = 0;
	int bad_count = 0, compares = 0;
	logic [9:0] ri [6] = '{10'h100, 10'h153, 10'h154, 10'h0b1, 10'h0b2, 10'h101};
	logic [15:0] rw [6] = '{16'ha5c3, 16'h1234, 16'hffff, 16'hffff, 16'hffff, 16'h0180};
	logic [15:0] re [6] = '{16'ha5c3, 16'h1234, 16'h0000, 16'h0000, 16'h0000, 16'h0180};
	fsq_if link_if();
	// Free-running core clock.
	always #5 core_clk = ~core_clk;
	// Serial statistics word, shifted in while the frame is high.
	always @(posedge core_clk) if (tx_frame) tx_word <= {tx_word[30:0], tx_bit};
	fsq_dev #(.H_TOTAL_P(16), .H_BLANK_P(4), .V_TOTAL_P(8), .V_BLANK_P(2)) fsq_dev_inst (
		.core_clk(core_clk), .rst_b(rst_b), .link(link_if), .cr_sample(cr_sample),
		.cr_valid(cr_valid), .q_pair(q_pair), .q_bin_width(qbw), .q_recip_width(qrw),
		.active_video(act), .field_one(field_one), .dsp_tx_bit(tx_bit), .dsp_tx_frame(tx_frame),
		.dsp_rx_bit(rx_bit), .dsp_rx_frame(rx_frame));
	fsq_host fsq_host_inst (.core_clk(core_clk), .rst_b(rst_b), .link(link_if),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_vsync(ext_vsync),
		.ext_hsync(ext_hsync), .ext_field(ext_field));
	fsq_link_monitor fsq_link_monitor_inst (.core_clk(core_clk), .rst_b(rst_b),
		.reg_index(link_if.reg_index), .reg_wr(link_if.reg_wr), .reg_rd(link_if.reg_rd),
		.reg_rdata(link_if.reg_rdata), .reg_rvalid(link_if.reg_rvalid),
		.vsync_dev_o(link_if.vsync_dev_o), .vsync_dev_oe(link_if.vsync_dev_oe),
		.hsync_dev_o(link_if.hsync_dev_o), .field_dev_o(link_if.field_dev_o),
		.vsync_line(link_if.vsync_line), .coding_direction(link_if.coding_direction),
		.stats_ready(link_if.stats_ready));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do @(posedge core_clk); while (!awready);
		awvalid <= 0;
		wvalid <= 0;
		do @(posedge core_clk); while (!bvalid);
		bready <= 0;
	endtask
	task automatic axi_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge core_clk); while (!arready);
		arvalid <= 0;
		do @(posedge core_clk); while (!rvalid);
		d = rdata;
		rready <= 0;
	endtask
	task automatic ind_wr(input logic [9:0] i, input logic [15:0] d);
		axi_wr(A_INDEX, {22'h0, i});
		axi_wr(A_WDATA, {16'h0, d});
		axi_wr(A_CTRL, 32'h1);
		do axi_rd(A_STATUS, s); while (s[0]);
	endtask
	task automatic ind_rd(input logic [9:0] i, output logic [31:0] d);
		axi_wr(A_INDEX, {22'h0, i});
		axi_wr(A_CTRL, 32'h2);
		do axi_rd(A_STATUS, s); while (s[0]);
		axi_rd(A_RDATA, d);
	endtask
	// One slave field holding two samples, then a long blanking stretch.
	task automatic run_field(input logic [15:0] lo, input logic [15:0] hi);
		@(posedge core_clk);
		ext_vsync <= 0;
		repeat (8) @(posedge core_clk);
		cr_sample <= lo;
		cr_valid <= 1;
		@(posedge core_clk);
		cr_sample <= hi;
		chk(32'(act), 32'h1);
		@(posedge core_clk);
		cr_valid <= 0;
		repeat (4) @(posedge core_clk);
		ext_vsync <= 1;
		repeat (150) @(posedge core_clk);
		chk(32'(act), 32'h0);
	endtask
	// Watchdog that cuts a hang short.
	initial begin
		#300us;
		bad_count++;
		give_verdict();
	end
	// Main sequence: table rows, then fields, then master timing.
	initial begin
		repeat (2) @(posedge core_clk);
		rst_b <= 1;
		for (int i = 0; i < 6; i++) begin
			ind_wr(ri[i], rw[i]);
			ind_rd(ri[i], r);
			chk(r, {16'h0, re[i]});
		end
		wstrb <= 4'h2;
		axi_wr(A_WDATA, 32'h0000_ab00);
		wstrb <= 4'hf;
		axi_rd(A_WDATA, r);
		chk(r, 32'h0000_ab80);
		// One serial frame writes a table entry from the DSP side.
		for (int i = 31; i >= 0; i--) begin
			rx_bit <= dsp_w[i];
			rx_frame <= 1;
			@(posedge core_clk);
		end
		rx_frame <= 0;
		ind_rd(10'h102, r);
		chk(r, 32'h0000_3c5a);
		$display("table rows done");
		chk(32'(link_if.vsync_dev_oe), 32'h0);
		#2 chk(32'(link_if.video_clock_out), 32'h1);
		@(posedge core_clk);
		ext_field <= 1;
		run_field(16'h0050, 16'h0300);
		ind_rd(IDX_CR_MIN, r);
		chk(r, 32'h0050);
		ind_rd(IDX_CR_MAX, r);
		chk(r, 32'h0300);
		chk(tx_word, 32'h00500300);
		chk(32'(link_if.stats_ready), 32'h1);
		chk(32'(field_one), 32'h1);
		repeat (2) @(posedge core_clk);
		chk({qbw, qrw}, 32'h0180a5c3);
		ind_wr(10'h100, 16'h2222);
		ind_wr(IDX_STATUS, 16'h1);
		repeat (2) @(posedge core_clk);
		chk({qbw, qrw}, 32'h0180a5c3);
		chk(32'(link_if.stats_ready), 32'h0);
		run_field(16'h0100, 16'h0200);
		ind_rd(IDX_CR_MIN, r);
		chk(r, 32'h0100);
		ind_rd(IDX_CR_MAX, r);
		chk(r, 32'h0200);
		chk({qbw, qrw}, 32'h01802222);
		q_pair <= 6'(TBL_PAIRS);
		repeat (2) @(posedge core_clk);
		chk({qbw, qrw}, 32'h0);
		$display("field tests done");
		ind_wr(IDX_MODE, 16'h1);
		repeat (400) @(posedge core_clk);
		chk(32'(link_if.vsync_dev_oe), 32'h1);
		ind_wr(IDX_MODE, 16'h3);
		repeat (400) @(posedge core_clk);
		ind_wr(IDX_MODE, 16'hd);
		repeat (2) @(posedge core_clk);
		#2 r[0] = link_if.video_clock_out;
		@(posedge core_clk);
		#2 chk(32'(link_if.video_clock_out ^ r[0]), 32'h1);
		chk(32'(link_if.coding_direction), 32'h1);
		$display("master tests done");
		// Reset in mid-run must not fake a field or keep the old mode.
		@(posedge core_clk);
		rst_b <= 0;
		@(posedge core_clk);
		rst_b <= 1;
		repeat (3) @(posedge core_clk);
		chk(32'(link_if.vsync_dev_oe), 32'h0);
		chk(32'(link_if.coding_direction), 32'h0);
		chk(32'(link_if.stats_ready), 32'h0);
		$display("reset tests done");
		give_verdict();
	end
endmodule
